// ==== hw/fpl_cfg.svh ====
/*
 Front-panel indicator block: offsets, codes and timing figures.
 Assumes a single 200 MHz system clock; included by bare name.
*/
`ifndef FPL_CFG_SVH
`define FPL_CFG_SVH

// Clock rate and times
`define FPL_CLK_MHZ   200
`define FPL_HOLD_MS   5000
`define FPL_DEB_MS    20
`define FPL_ON_MS     250
`define FPL_OFF_MS    250
`define FPL_PAUSE_MS  1000
`define FPL_ACT_MS    50
`define FPL_RST_CYC   5'h10

// Bit positions in the synchronised pin vector
`define FPL_PIN_ON    0
`define FPL_PIN_PRI   1
`define FPL_PIN_SEC   2
`define FPL_PIN_PSU   3
`define FPL_PIN_BASE  4

// Ethernet speed codes from the PHY
`define FPL_SPD_100   2'h1
`define FPL_SPD_1000  2'h2

// Blink group sizes
`define FPL_N_AUTO    3'h2
`define FPL_N_USER    3'h3
`define FPL_N_EXC     3'h4

`endif

// ==== hw/fpl_pkg.sv ====
/*
 Types shared by the front-panel indicator block.
 Assumes nothing beyond the constants header.
*/
package fpl_pkg;

    typedef enum logic [1:0] {
        BL_OFF,
        BL_SOLID,
        BL_CONT,
        BL_GROUP
    } fpl_blink_t;

    typedef enum logic [1:0] {
        PH_ON,
        PH_OFF,
        PH_PAUSE
    } fpl_bph_t;

endpackage

// ==== hw/fpl_btn_if.sv ====
/*
 Press events from the reset-button timer to the panel controller.
 Assumes both ends share the system clock.
*/
`timescale 1ns/100ps
`default_nettype none

interface fpl_btn_if;
    logic short_rel;
    logic long_hit;
    logic long_rel;
    logic held;

    modport drv (output short_rel, output long_hit, output long_rel,
                 output held);
    modport use_ (input short_rel, input long_hit, input long_rel,
                  input held);
endinterface

`default_nettype wire

// ==== hw/fpl_button.sv ====
/*
 Reset button synchroniser, debouncer and press-length timer.
 Assumes an active-low button pin, asynchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none

module fpl_button #(
    parameter int unsigned DEB_CYC  = 32'd4000000,
    parameter int unsigned HOLD_CYC = 32'd1000000000
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // Button pin
    input  wire logic rst_btn_n,
    // Press events
    fpl_btn_if.drv    btn
);

    typedef struct packed {
        logic        s1;
        logic        s2;
        logic        deb;
        logic [31:0] dcnt;
        logic [31:0] hcnt;
        logic        long_;
        logic        short_rel;
        logic        long_hit;
        logic        long_rel;
    } fpl_btn_st_t;

    fpl_btn_st_t st_reg;
    fpl_btn_st_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.s1 = rst_btn_n;
        st_next.s2 = st_reg.s1;
        st_next.short_rel = 1'b0;
        st_next.long_hit = 1'b0;
        st_next.long_rel = 1'b0;
        // Level must hold steady a full window before it is believed
        if (st_reg.deb == st_reg.s2) begin
            if (st_reg.dcnt == DEB_CYC - 32'd1) begin
                st_next.deb = ~st_reg.s2;
                st_next.dcnt = 32'h0;
            end else begin
                st_next.dcnt = st_reg.dcnt + 32'd1;
            end
        end else begin
            st_next.dcnt = 32'h0;
        end
        if (st_reg.deb) begin
            if (st_reg.hcnt == HOLD_CYC - 32'd1) begin
                st_next.long_ = 1'b1;
                st_next.long_hit = ~st_reg.long_;
            end else begin
                st_next.hcnt = st_reg.hcnt + 32'd1;
            end
            if (st_next.deb == 1'b0) begin
                // Release on the hold mark itself still counts as short
                st_next.long_hit = 1'b0;
                st_next.long_rel = st_reg.long_;
                st_next.short_rel = ~st_reg.long_;
                st_next.long_ = 1'b0;
                st_next.hcnt = 32'h0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= '{s1: 1'b1, s2: 1'b1, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign btn.short_rel = st_reg.short_rel;
    assign btn.long_hit  = st_reg.long_hit;
    assign btn.long_rel  = st_reg.long_rel;
    assign btn.held      = st_reg.deb;

    ////////////////////////////////////////////////////////////////////////
    a_deb_settle: assert property (@(posedge clk) disable iff (sys_rst)
        $changed(st_reg.deb) |-> $past(st_reg.dcnt) == DEB_CYC - 32'd1)
        else $error("debounced level moved before settling");
    a_hold_mark: assert property (@(posedge clk) disable iff (sys_rst)
        st_reg.long_hit |-> st_reg.hcnt == HOLD_CYC - 32'd1 && st_reg.deb)
        else $error("long press flagged at wrong time");

endmodule

`default_nettype wire

// ==== hw/fpl_panel.sv ====
/*
 Front-panel indicators and reset-button actions of the controller.
 Assumes firmware flags on clk; pins, PoE and PHY signals are async.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fpl_cfg.svh"

module fpl_panel #(
    parameter int          N_ETH     = 5,
    parameter int          N_POE     = 4,
    parameter int unsigned HOLD_CYC  = `FPL_HOLD_MS * 1000 * `FPL_CLK_MHZ,
    parameter int unsigned DEB_CYC   = `FPL_DEB_MS * 1000 * `FPL_CLK_MHZ,
    parameter int unsigned ON_CYC    = `FPL_ON_MS * 1000 * `FPL_CLK_MHZ,
    // Off and pause follow the on time, so one figure sets the code pace
    parameter int unsigned OFF_CYC   = ON_CYC * (`FPL_OFF_MS / `FPL_ON_MS),
    parameter int unsigned PAUSE_CYC = ON_CYC * (`FPL_PAUSE_MS / `FPL_ON_MS),
    parameter int unsigned ACT_CYC   = `FPL_ACT_MS * 1000 * `FPL_CLK_MHZ
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // Supply monitor pins
    input  wire logic             sys_on,
    input  wire logic             primary_supply_input,
    input  wire logic             secondary_supply_input,
    input  wire logic             psu_fail,
    // Port pins
    input  wire logic [N_POE-1:0] poe_pwr,
    input  wire logic [N_ETH-1:0] eth_link,
    input  wire logic [N_ETH-1:0] eth_act,
    input  wire logic [2*N_ETH-1:0] eth_spd,
    // Button pin
    input  wire logic             rst_btn_n,
    // Firmware flags
    input  wire logic             init_done,
    input  wire logic             rt_booting,
    input  wire logic             desktop_os,
    input  wire logic             drive_access,
    input  wire logic             safe_auto,
    input  wire logic             boot_fail,
    input  wire logic             exc_evt,
    input  wire logic             addr_static_set,
    input  wire logic [1:0]       software_user_indicator,
    input  wire logic [1:0]       logic_user_indicator,
    // Panel lights
    output logic                  pwr_led_grn,
    output logic                  pwr_led_yel,
    output logic                  stat_led_yel,
    output logic                  stat_led_red,
    output logic [1:0]            user_sw_led,
    output logic [1:0]            user_logic_led,
    output logic [N_POE-1:0]      poe_led,
    output logic [N_ETH-1:0]      spd_led_grn,
    output logic [N_ETH-1:0]      spd_led_amb,
    output logic [N_ETH-1:0]      lnk_led,
    // System actions
    output logic                  cpu_reset,
    output logic                  safe_mode,
    output logic                  console_en,
    output logic                  net_reset,
    output logic                  addr_auto
);

    localparam int PW  = `FPL_PIN_BASE + N_POE + 4 * N_ETH;
    localparam int LNK = `FPL_PIN_BASE + N_POE;
    localparam int ACT = LNK + N_ETH;
    localparam int SPD = ACT + N_ETH;

    typedef struct packed {
        logic [PW-1:0]       pin1;
        logic [PW-1:0]       pin2;
        fpl_pkg::fpl_bph_t   bph;
        logic [31:0]         bcnt;
        logic [2:0]          blk;
        fpl_pkg::fpl_blink_t mode_prev;
        logic [2:0]          n_prev;
        logic [31:0]         acnt;
        logic                wave;
        logic [N_ETH-1:0]    act_hold;
        logic                safe;
        logic                console;
        logic                addr_auto;
        logic                net_rst;
        logic [4:0]          rcnt;
        logic                cpu_rst;
        logic                exc_seen;
        logic                exc_lock;
        logic                pwr_g;
        logic                pwr_y;
        logic                st_y;
        logic                st_r;
        logic [1:0]          u_sw;
        logic [1:0]          u_lg;
        logic [N_POE-1:0]    poe;
        logic [N_ETH-1:0]    sg;
        logic [N_ETH-1:0]    sa;
        logic [N_ETH-1:0]    lk;
    } fpl_st_t;

    fpl_st_t             st_reg;
    fpl_st_t             st_next;
    fpl_pkg::fpl_blink_t mode;
    logic [2:0]          grp_n;
    logic                red_sel;
    logic                lit;
    logic [PW-1:0]       pins;
    logic [PW-1:0]       s;

    fpl_btn_if btn ();

    fpl_button #(
        .DEB_CYC  (DEB_CYC),
        .HOLD_CYC (HOLD_CYC)
    ) u_btn (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .rst_btn_n (rst_btn_n),
        .btn       (btn)
    );

    assign pins = {eth_spd, eth_act, eth_link, poe_pwr, psu_fail,
                   secondary_supply_input, primary_supply_input, sys_on};
    assign s = st_reg.pin2;

    ////////////////////////////////////////////////////////////////////////
    // Status light selection, most urgent first
    always_comb begin
        red_sel = 1'b0;
        grp_n = 3'h0;
        if (s[`FPL_PIN_PSU]) begin
            mode = fpl_pkg::BL_CONT;
            red_sel = 1'b1;
        end else if (st_reg.exc_lock) begin
            mode = fpl_pkg::BL_GROUP;
            grp_n = `FPL_N_EXC;
        end else if (st_reg.safe) begin
            mode = fpl_pkg::BL_GROUP;
            grp_n = `FPL_N_USER;
        end else if (safe_auto) begin
            mode = fpl_pkg::BL_GROUP;
            grp_n = `FPL_N_AUTO;
        end else if (boot_fail) begin
            mode = fpl_pkg::BL_CONT;
        end else if (rt_booting || (desktop_os && drive_access)) begin
            mode = fpl_pkg::BL_SOLID;
        end else if (init_done) begin
            mode = fpl_pkg::BL_OFF;
        end else begin
            // Still coming up with no flag yet: show as booting
            mode = fpl_pkg::BL_SOLID;
        end
        lit = (mode == fpl_pkg::BL_SOLID) ||
              ((mode == fpl_pkg::BL_CONT || mode == fpl_pkg::BL_GROUP) &&
               st_reg.bph == fpl_pkg::PH_ON);
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_next = st_reg;
        st_next.pin1 = pins;
        st_next.pin2 = st_reg.pin1;

        // Blink engine; restarts cleanly so a new code starts with a blink
        st_next.bcnt = st_reg.bcnt + 32'd1;
        if (mode != st_reg.mode_prev || grp_n != st_reg.n_prev) begin
            st_next.bph = fpl_pkg::PH_ON;
            st_next.bcnt = 32'h0;
            st_next.blk = 3'h0;
        end else begin
            case (st_reg.bph)
                fpl_pkg::PH_ON: begin
                    if (st_reg.bcnt == ON_CYC - 32'd1) begin
                        st_next.bph = fpl_pkg::PH_OFF;
                        st_next.bcnt = 32'h0;
                        st_next.blk = st_reg.blk + 3'h1;
                    end
                end
                fpl_pkg::PH_OFF: begin
                    if (st_reg.bcnt == OFF_CYC - 32'd1) begin
                        st_next.bcnt = 32'h0;
                        if (mode == fpl_pkg::BL_GROUP &&
                            st_reg.blk == grp_n) begin
                            st_next.bph = fpl_pkg::PH_PAUSE;
                            st_next.blk = 3'h0;
                        end else begin
                            st_next.bph = fpl_pkg::PH_ON;
                        end
                    end
                end
                default: begin
                    if (st_reg.bcnt == PAUSE_CYC - 32'd1) begin
                        st_next.bph = fpl_pkg::PH_ON;
                        st_next.bcnt = 32'h0;
                    end
                end
            endcase
        end
        st_next.mode_prev = mode;
        st_next.n_prev = grp_n;
        st_next.st_y = lit && !red_sel;
        st_next.st_r = lit && red_sel;

        // Power and user lights
        st_next.pwr_g = s[`FPL_PIN_ON] && s[`FPL_PIN_PRI];
        st_next.pwr_y = s[`FPL_PIN_ON] && !s[`FPL_PIN_PRI] &&
                        s[`FPL_PIN_SEC];
        st_next.u_sw = software_user_indicator;
        st_next.u_lg = logic_user_indicator;
        st_next.poe = s[`FPL_PIN_BASE +: N_POE];

        // Shared traffic blink; a burst is held only until the current period ends
        if (st_reg.acnt == ACT_CYC - 32'd1) begin
            st_next.acnt = 32'h0;
            st_next.wave = ~st_reg.wave;
            st_next.act_hold = '0;
        end else begin
            st_next.acnt = st_reg.acnt + 32'd1;
        end
        for (int i = 0; i < N_ETH; i++) begin
            if (s[ACT + i]) begin
                st_next.act_hold[i] = 1'b1;
            end
            st_next.sg[i] = s[LNK + i] &&
                            s[SPD + 2*i +: 2] == `FPL_SPD_100;
            st_next.sa[i] = s[LNK + i] &&
                            s[SPD + 2*i +: 2] == `FPL_SPD_1000;
            st_next.lk[i] = s[LNK + i] &&
                            !(st_reg.act_hold[i] && st_reg.wave);
        end

        // Button actions
        st_next.net_rst = 1'b0;
        st_next.rcnt = (st_reg.rcnt != 5'h0) ? st_reg.rcnt - 5'h1 : 5'h0;
        if (btn.short_rel) begin
            st_next.rcnt = `FPL_RST_CYC;
            st_next.safe = 1'b0;
            st_next.console = 1'b0;
            st_next.exc_seen = 1'b0;
            st_next.exc_lock = 1'b0;
        end
        if (btn.long_rel && !st_reg.safe) begin
            st_next.rcnt = `FPL_RST_CYC;
            st_next.safe = 1'b1;
            st_next.console = 1'b1;
            st_next.exc_seen = 1'b0;
            st_next.exc_lock = 1'b0;
        end
        if (addr_static_set) begin
            st_next.addr_auto = 1'b0;
        end
        if (btn.long_hit && st_reg.safe) begin
            st_next.net_rst = 1'b1;
            st_next.addr_auto = 1'b1;
        end

        // Exceptions; a clean start forgets the first one
        if (init_done && !st_reg.exc_lock) begin
            st_next.exc_seen = 1'b0;
        end
        if (exc_evt) begin
            if (st_reg.exc_seen) begin
                st_next.exc_lock = 1'b1;
            end else begin
                st_next.exc_seen = 1'b1;
                st_next.rcnt = `FPL_RST_CYC;
            end
        end
        st_next.cpu_rst = st_next.rcnt != 5'h0;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= '{bph: fpl_pkg::PH_ON, mode_prev: fpl_pkg::BL_OFF,
                        addr_auto: 1'b1, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign pwr_led_grn    = st_reg.pwr_g;
    assign pwr_led_yel    = st_reg.pwr_y;
    assign stat_led_yel   = st_reg.st_y;
    assign stat_led_red   = st_reg.st_r;
    assign user_sw_led    = st_reg.u_sw;
    assign user_logic_led = st_reg.u_lg;
    assign poe_led        = st_reg.poe;
    assign spd_led_grn    = st_reg.sg;
    assign spd_led_amb    = st_reg.sa;
    assign lnk_led        = st_reg.lk;
    assign cpu_reset      = st_reg.cpu_rst;
    assign safe_mode      = st_reg.safe;
    assign console_en     = st_reg.console;
    assign net_reset      = st_reg.net_rst;
    assign addr_auto      = st_reg.addr_auto;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_pwr_colour: assert property (
        s[`FPL_PIN_ON] && s[`FPL_PIN_PRI] |=> pwr_led_grn && !pwr_led_yel)
        else $error("power light not green on primary");
    a_red_fault: assert property (
        s[`FPL_PIN_PSU] ##1 s[`FPL_PIN_PSU] |=> !stat_led_yel)
        else $error("yellow shown during supply fault");
    a_group_pause: assert property (
        st_reg.bph == fpl_pkg::PH_PAUSE && $stable(mode) && $stable(grp_n)
        |=> !stat_led_yel && !stat_led_red)
        else $error("light lit during group pause");
    a_exc_restart: assert property (
        exc_evt && !st_reg.exc_seen |=> cpu_reset [*8])
        else $error("first exception did not restart");
    a_exc_lock: assert property (
        exc_evt && st_reg.exc_seen && !btn.short_rel
        |=> st_reg.exc_lock && grp_n == `FPL_N_EXC || s[`FPL_PIN_PSU])
        else $error("second exception not locked");
    a_press_reset: assert property (
        btn.short_rel |=> cpu_reset ##15 cpu_reset)
        else $error("short press gave no reset");
    a_safe_enter: assert property (
        btn.long_rel && !safe_mode |=> safe_mode && console_en)
        else $error("long press did not enter safe mode");
    a_net_reset: assert property (
        btn.long_hit && safe_mode |=> net_reset && addr_auto ##1 !net_reset)
        else $error("network reset missing");
    a_safe_leave: assert property (
        btn.short_rel && safe_mode |=> !safe_mode && !console_en)
        else $error("short press did not leave safe mode");
    a_link_dark: assert property (
        !s[LNK] |=> !lnk_led[0] && !spd_led_grn[0] && !spd_led_amb[0])
        else $error("port light lit without link");
    a_poe_follow: assert property (
        s[`FPL_PIN_BASE] |=> poe_led[0])
        else $error("PoE light dark while powering");

    c_short: cover property (btn.short_rel && !safe_mode);
    c_safe_net: cover property (btn.long_hit && safe_mode);
    c_exc_lock: cover property ($rose(st_reg.exc_lock));
    c_pause: cover property (st_reg.bph == fpl_pkg::PH_PAUSE);

endmodule

`default_nettype wire

// ==== test/fpl_operator.sv ====
/*
 Operator model: holds the reset button down for a given time.
 Assumes clk is the panel clock; the model drives the pin high when idle.
*/
`timescale 1ns/100ps
`default_nettype none

module fpl_operator (
    // Clock
    input  wire logic clk,
    // Button pin
    output var logic  rst_btn_n
);
    initial rst_btn_n = 1'b1;

    // Low for n cycles, then released; the model drives it back high
    task automatic press(input int n);
        @(negedge clk);
        rst_btn_n = 1'b0;
        repeat (n) @(negedge clk);
        rst_btn_n = 1'b1;
    endtask
endmodule

`default_nettype wire

// ==== test/tb_front_panel_led_and_reset_control.sv ====
/*
 Self-checking bench for the front-panel block with shortened timings.
 Assumes the operator model owns the button pin.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_front_panel_led_and_reset_control;
    localparam int OFF  = 10;
    localparam int HOLD = 200;
    logic       clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       sys_on = 1'b0, primary_supply_input = 1'b0;
    logic       secondary_supply_input = 1'b0, psu_fail = 1'b0;
    logic       init_done = 1'b0, rt_booting = 1'b0, desktop_os = 1'b0;
    logic       drive_access = 1'b0, safe_auto = 1'b0, boot_fail = 1'b0;
    logic       exc_evt = 1'b0, addr_static_set = 1'b0, rst_btn_n;
    logic [3:0] poe_pwr = 4'h0, poe_led;
    logic [4:0] eth_link = 5'h00, eth_act = 5'h00;
    logic [4:0] spd_led_grn, spd_led_amb, lnk_led;
    logic [9:0] eth_spd = 10'h000;
    logic [1:0] software_user_indicator = 2'h0, logic_user_indicator = 2'h0;
    logic [1:0] user_sw_led, user_logic_led;
    logic       pwr_led_grn, pwr_led_yel, stat_led_yel, stat_led_red;
    logic       cpu_reset, safe_mode, console_en, net_reset, addr_auto;
    int         n_errors = 0;
    int         samples_checked = 0;

    always #2.5 clk = ~clk;

    fpl_panel #(.HOLD_CYC(HOLD), .DEB_CYC(8), .ON_CYC(OFF),
                .ACT_CYC(16)) dut (
        .clk, .sys_rst, .sys_on, .primary_supply_input,
        .secondary_supply_input, .psu_fail, .poe_pwr, .eth_link, .eth_act,
        .eth_spd, .rst_btn_n, .init_done, .rt_booting, .desktop_os,
        .drive_access, .safe_auto, .boot_fail, .exc_evt, .addr_static_set,
        .software_user_indicator, .logic_user_indicator, .pwr_led_grn,
        .pwr_led_yel, .stat_led_yel, .stat_led_red, .user_sw_led,
        .user_logic_led, .poe_led, .spd_led_grn, .spd_led_amb, .lnk_led,
        .cpu_reset, .safe_mode, .console_en, .net_reset, .addr_auto);

    fpl_operator op (.clk, .rst_btn_n);

    ////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_n(input string nm, input int e, g);
        samples_checked++;
        if (g != e) begin
            n_errors++;
            $display("mismatch %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    task automatic end_sim;
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Bounded wait for a pulse, then its width in cycles
    task automatic pw(input bit net, input int lim, output int w);
        int k;
        w = 0;
        for (k = 0; k < lim && (net ? net_reset : cpu_reset) !== 1'b1; k++)
            cyc(1);
        if (k == lim) begin
            n_errors++;
            $display("mismatch pulse expected 1 seen 0");
            end_sim();
        end
        while ((net ? net_reset : cpu_reset) === 1'b1 && w < 100) begin
            w++;
            cyc(1);
        end
    endtask

    task automatic quiet(input int n, output int hits);
        hits = 0;
        repeat (n) begin
            cyc(1);
            if (cpu_reset !== 1'b0) hits++;
        end
    endtask

    // Blinks per group (0 if no pause seen) and total rises
    task automatic meas(input bit red, output int n, r);
        int   ph, dk, k;
        logic v, pv;
        ph = 0;
        dk = 0;
        n = 0;
        r = 0;
        pv = 1'b1;
        for (k = 0; k < 2000 && ph < 2; k++) begin
            cyc(1);
            v = red ? stat_led_red : stat_led_yel;
            if (v === 1'b1 && pv !== 1'b1) r++;
            if (ph == 1 && v === 1'b1 && pv !== 1'b1) n++;
            dk = (v === 1'b1) ? 0 : dk + 1;
            if (dk > OFF + 2) ph = (ph == 0 || n == 0) ? 1 : 2;
            pv = v;
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_power;
        logic [2:0] c [3] = '{3'b110, 3'b101, 3'b011};
        logic [1:0] e [3] = '{2'b10, 2'b01, 2'b00};
        for (int i = 0; i < 3; i++) begin
            @(negedge clk);
            {sys_on, primary_supply_input, secondary_supply_input} = c[i];
            cyc(4);
            chk("power", e[i], {pwr_led_grn, pwr_led_yel});
        end
        $display("power test done");
    endtask

    task automatic t_ports;
        int dk;
        @(negedge clk);
        {poe_pwr, eth_link, eth_spd} = {4'ha, 5'h1e, 10'h1e4};
        cyc(4);
        chk("poe", 4'ha, poe_led);
        chk("spd grn", 5'h12, spd_led_grn);
        chk("spd amb", 5'h04, spd_led_amb);
        chk("link", 5'h1e, lnk_led);
        @(negedge clk);
        {poe_pwr, eth_act} = {4'h5, 5'h02};
        dk = 0;
        repeat (64) begin
            cyc(1);
            if (lnk_led[1] === 1'b0) dk++;
        end
        chk_n("act dark", 1, dk > 0);
        chk("link idle", 1'b1, lnk_led[2]);
        chk("poe", 4'h5, poe_led);
        @(negedge clk);
        {eth_link, eth_act} = 10'h000;
        cyc(4);
        chk("no link", 10'h000, {lnk_led, spd_led_grn});
        $display("ports test done");
    endtask

    task automatic t_user;
        @(negedge clk);
        {software_user_indicator, logic_user_indicator} = 4'h6;
        cyc(2);
        chk("user", 4'h6, {user_sw_led, user_logic_led});
        @(negedge clk);
        {software_user_indicator, logic_user_indicator} = 4'h9;
        cyc(2);
        chk("user", 4'h9, {user_sw_led, user_logic_led});
        $display("user test done");
    endtask

    task automatic t_status;
        int n, r;
        @(negedge clk);
        {rt_booting, init_done} = 2'b11;
        cyc(3);
        chk("booting", 1'b1, stat_led_yel);
        @(negedge clk);
        {rt_booting, desktop_os, drive_access} = 3'b011;
        cyc(3);
        chk("drive", 1'b1, stat_led_yel);
        @(negedge clk);
        {drive_access, init_done} = 2'b01;
        cyc(3);
        chk("ready", 1'b0, stat_led_yel);
        @(negedge clk);
        boot_fail = 1'b1;
        meas(1'b0, n, r);
        chk_n("cont grp", 0, n);
        chk_n("cont rises", 1, r >= 99);
        @(negedge clk);
        safe_auto = 1'b1;
        meas(1'b0, n, r);
        chk_n("auto blinks", 2, n);
        @(negedge clk);
        psu_fail = 1'b1;
        meas(1'b1, n, r);
        chk_n("red rises", 1, n == 0 && r >= 99);
        @(negedge clk);
        {psu_fail, safe_auto, boot_fail, init_done} = 4'h0;
        cyc(6);
        $display("status test done");
    endtask

    task automatic t_exc;
        int w, n, r;
        @(negedge clk);
        exc_evt = 1'b1;
        @(negedge clk);
        exc_evt = 1'b0;
        pw(1'b0, 5, w);
        chk_n("exc reset", 16, w);
        @(negedge clk);
        exc_evt = 1'b1;
        @(negedge clk);
        exc_evt = 1'b0;
        meas(1'b0, n, r);
        chk_n("exc blinks", 4, n);
        $display("exception test done");
    endtask

    task automatic t_button;
        int w, n, r;
        op.press(4);
        quiet(40, w);
        chk_n("glitch", 0, w);
        op.press(50);
        pw(1'b0, 40, w);
        chk_n("short reset", 16, w);
        cyc(2);
        chk("lock cleared", 1'b1, stat_led_yel);
        op.press(HOLD + 100);
        pw(1'b0, 40, w);
        chk_n("long reset", 16, w);
        chk("safe", 2'b11, {safe_mode, console_en});
        meas(1'b0, n, r);
        chk_n("user blinks", 3, n);
        @(negedge clk);
        addr_static_set = 1'b1;
        @(negedge clk);
        addr_static_set = 1'b0;
        cyc(1);
        chk("static", 1'b0, addr_auto);
        fork
            op.press(HOLD + 100);
        join_none
        pw(1'b1, 400, w);
        chk_n("net pulse", 1, w);
        chk("auto addr", 1'b1, addr_auto);
        quiet(150, w);
        chk_n("net release", 0, w);
        chk("still safe", 2'b11, {safe_mode, console_en});
        op.press(50);
        pw(1'b0, 40, w);
        chk_n("leave reset", 16, w);
        chk("left safe", 2'b00, {safe_mode, console_en});
        $display("button test done");
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        cyc(10);
        chk("reset lights", 16'h0000,
            {pwr_led_grn, pwr_led_yel, stat_led_yel, stat_led_red, poe_led,
             lnk_led, spd_led_amb[1:0]});
        chk("reset actions", 5'h01,
            {cpu_reset, safe_mode, console_en, net_reset, addr_auto});
        @(negedge clk);
        sys_rst = 1'b0;
        t_power();
        t_ports();
        t_user();
        t_status();
        t_exc();
        t_button();
        end_sim();
    end
endmodule

`default_nettype wire
